// ==== src/irq_pkg.sv ====
// shared constants and carrier types for the tick and interrupt block
package irq_pkg;
	localparam int NUM_VEC = 11;
	localparam int NUM_GROUPS = 7;
	localparam int NUM_MEMBERS = 17;
	localparam int ADDR_W = 8;
	localparam int TICK_COUNT_W = 15;
	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_TICK_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CONTROL = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_MEMBER_FLAGS = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_MEMBER_ENABLE = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h14;
	// tick control fields
	localparam int TC_RUN_BIT = 7;
	localparam int TC_SEL_BIT = 6;
	localparam int TC_PERIOD_LSB = 4;
	localparam logic [1:0] TC_PERIOD_RESET = 2'h3;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	// irq control fields: bit 0 global, bits 11:1 per-vector enables
	localparam int CTL_GLOBAL_BIT = 0;
	localparam int CTL_ENABLE_LSB = 1;
	// status fields
	localparam int STAT_REQ_BIT = 4;
	localparam int STAT_STACK_BIT = 5;
	localparam int STAT_GLOBAL_BIT = 6;
	// vector indices, lower index is higher priority
	localparam logic [3:0] VEC_TICK = 4'h0;
	localparam logic [3:0] VEC_GROUP0 = 4'h1;
	localparam logic [3:0] VEC_NVM = 4'h8;
	localparam logic [3:0] VEC_LOWV = 4'h9;
	localparam logic [3:0] VEC_TWOWIRE = 4'ha;
	localparam logic [15:0] VEC_BASE = 16'h0004;
	localparam logic [15:0] VEC_STEP = 16'h0004;
	// owning group of each member source
	localparam logic [2:0] MEMBER_GROUP [NUM_MEMBERS] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2,
		3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6};

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_type;

	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} ahb_resp_type;

	typedef struct packed {
		logic nvmDone;
		logic lowVolt;
		logic twowireByte;
		logic [NUM_MEMBERS-1:0] member;
		logic tickOsc;
	} src_event_type;

	typedef struct packed {
		logic ack;
		logic return_from_interrupt;
		logic stackFull;
	} core_in_type;

	typedef struct packed {
		logic req;
		logic [3:0] index;
		logic [15:0] vector;
		logic wake;
	} core_out_type;
endpackage

// ==== src/tick_divider.sv ====
// tick clock selection and programmable period divider
`timescale 1ns/10ps
module tick_divider import irq_pkg::*; #(
	parameter int BASE_CYCLES = 4096
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// control
	input wire logic run,
	input wire logic clockSelect,
	input wire logic [1:0] periodSelect,
	input wire logic oscPulse,
	// result
	output logic overflow
);
	logic [1:0] prescale;
	logic [TICK_COUNT_W-1:0] count;
	logic [TICK_COUNT_W-1:0] lastCount;
	logic tickEn;

	assign lastCount = TICK_COUNT_W'((BASE_CYCLES << periodSelect) - 1);
	assign tickEn = clockSelect ? (prescale == PRESCALE_LAST) : oscPulse;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prescale <= 2'h0;
		end else if (ce) begin
			prescale <= run ? prescale + 2'h1 : 2'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
			overflow <= 1'b0;
		end else if (ce) begin
			overflow <= 1'b0;
			if (!run) begin
				count <= '0;
			end else if (tickEn) begin
				if (count >= lastCount) begin
					count <= '0;
					overflow <= 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	chk_stop_no_tick: assert property (ce && !run |=> !overflow)
		else $error("tick overflow while generator stopped");
	chk_sys_prescale: assert property (ce && run && clockSelect && prescale != PRESCALE_LAST |=> !overflow)
		else $error("system tick advanced off the divide-by-four slot");
	chk_period_bound: assert property (ce && run && tickEn && count == lastCount |=> overflow && count == '0)
		else $error("tick period end not taken");
endmodule // tick_divider

// ==== src/irq_tick_ctrl.sv ====
// tick generator and interrupt request, enable and vectoring logic
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module irq_tick_ctrl import irq_pkg::*; #(
	parameter int TICK_BASE_CYCLES = 4096
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// register bus
	input wire ahb_req_type bus,
	output ahb_resp_type busResp,
	// source events
	input wire src_event_type events,
	// processor core
	input wire core_in_type core,
	output core_out_type coreOut
);
	logic dataPhase;
	logic dataWrite;
	logic [ADDR_W-1:0] dataAddr;
	logic [31:0] readData;
	logic [31:0] next_readData;
	logic addrTake;
	logic wrTick;
	logic wrCtl;
	logic wrFlags;
	logic wrMember;
	logic wrMemEn;

	logic tickRun;
	logic tickSel;
	logic [1:0] tickPeriod;
	logic tickOverflow;
	logic globalEnable;
	logic [NUM_VEC-1:0] vecEnable;
	logic [NUM_VEC-1:0] flags;
	logic [NUM_VEC-1:0] next_flags;
	logic [NUM_VEC-1:0] flagSet;
	logic [NUM_VEC-1:0] ackClr;
	logic [NUM_VEC-1:0] pend;
	logic [NUM_MEMBERS-1:0] memberFlags;
	logic [NUM_MEMBERS-1:0] next_memberFlags;
	logic [NUM_MEMBERS-1:0] memberEnable;
	logic [NUM_MEMBERS-1:0] memberHit;
	logic [NUM_GROUPS-1:0] groupSet;
	logic [NUM_VEC+NUM_MEMBERS-1:0] prevAll;
	logic irqReq;
	logic ackNow;
	logic [3:0] vecIndex;
	logic [3:0] pick;
	logic [15:0] vecAddr;
	logic wake;

	// bus slave, zero wait states while ce is high
	assign addrTake = ce && bus.hsel && bus.htrans[1] && bus.hready;
	assign busResp = '{hreadyout: ce, hresp: 1'b0, hrdata: readData};
	assign coreOut = '{req: irqReq, index: vecIndex, vector: vecAddr, wake: wake};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dataPhase <= 1'b0;
			dataWrite <= 1'b0;
			dataAddr <= '0;
		end else if (ce && bus.hready) begin
			dataPhase <= addrTake;
			dataWrite <= bus.hwrite;
			dataAddr <= bus.haddr[ADDR_W-1:0];
		end
	end

	always_comb begin
		wrTick = 1'b0;
		wrCtl = 1'b0;
		wrFlags = 1'b0;
		wrMember = 1'b0;
		wrMemEn = 1'b0;
		if (!(ce && dataPhase && dataWrite)) begin
			wrTick = 1'b0;
		end else if (dataAddr == ADDR_TICK_CONTROL) begin
			wrTick = 1'b1;
		end else if (dataAddr == ADDR_IRQ_CONTROL) begin
			wrCtl = 1'b1;
		end else if (dataAddr == ADDR_IRQ_FLAGS) begin
			wrFlags = 1'b1;
		end else if (dataAddr == ADDR_MEMBER_FLAGS) begin
			wrMember = 1'b1;
		end else if (dataAddr == ADDR_MEMBER_ENABLE) begin
			wrMemEn = 1'b1;
		end
	end

	always_comb begin
		next_readData = '0;
		if (bus.haddr[ADDR_W-1:0] == ADDR_TICK_CONTROL) begin
			next_readData[TC_RUN_BIT] = tickRun;
			next_readData[TC_SEL_BIT] = tickSel;
			next_readData[TC_PERIOD_LSB +: 2] = tickPeriod;
		end else if (bus.haddr[ADDR_W-1:0] == ADDR_IRQ_CONTROL) begin
			next_readData[CTL_GLOBAL_BIT] = globalEnable;
			next_readData[CTL_ENABLE_LSB +: NUM_VEC] = vecEnable;
		end else if (bus.haddr[ADDR_W-1:0] == ADDR_IRQ_FLAGS) begin
			next_readData[NUM_VEC-1:0] = flags;
		end else if (bus.haddr[ADDR_W-1:0] == ADDR_MEMBER_FLAGS) begin
			next_readData[NUM_MEMBERS-1:0] = memberFlags;
		end else if (bus.haddr[ADDR_W-1:0] == ADDR_MEMBER_ENABLE) begin
			next_readData[NUM_MEMBERS-1:0] = memberEnable;
		end else if (bus.haddr[ADDR_W-1:0] == ADDR_IRQ_STATUS) begin
			next_readData[3:0] = vecIndex;
			next_readData[STAT_REQ_BIT] = irqReq;
			next_readData[STAT_STACK_BIT] = core.stackFull;
			next_readData[STAT_GLOBAL_BIT] = globalEnable;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			readData <= '0;
		end else if (addrTake && !bus.hwrite) begin
			readData <= next_readData;
		end
	end

	// tick control register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tickRun <= 1'b0;
			tickSel <= 1'b0;
			tickPeriod <= TC_PERIOD_RESET;
		end else if (wrTick) begin
			tickRun <= bus.hwdata[TC_RUN_BIT];
			tickSel <= bus.hwdata[TC_SEL_BIT];
			tickPeriod <= bus.hwdata[TC_PERIOD_LSB +: 2];
		end
	end

	tick_divider #(
		.BASE_CYCLES(TICK_BASE_CYCLES)
	) divider (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.run(tickRun),
		.clockSelect(tickSel),
		.periodSelect(tickPeriod),
		.oscPulse(events.tickOsc),
		.overflow(tickOverflow)
	);

	// enables
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			vecEnable <= '0;
			memberEnable <= '0;
		end else if (ce) begin
			if (wrCtl) begin
				vecEnable <= bus.hwdata[CTL_ENABLE_LSB +: NUM_VEC];
			end
			if (wrMemEn) begin
				memberEnable <= bus.hwdata[NUM_MEMBERS-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			globalEnable <= 1'b0;
		end else if (ce) begin
			if (ackNow) begin
				globalEnable <= 1'b0;
			end else if (core.return_from_interrupt) begin
				globalEnable <= 1'b1;
			end else if (wrCtl) begin
				globalEnable <= bus.hwdata[CTL_GLOBAL_BIT];
			end
		end
	end

	// group flags follow enabled member events
	assign memberHit = events.member & memberEnable;
	always_comb begin
		groupSet = '0;
		for (int m = 0; m < NUM_MEMBERS; m++) begin
			if (memberHit[m]) begin
				groupSet[MEMBER_GROUP[m]] = 1'b1;
			end
		end
	end

	assign flagSet = {events.twowireByte, events.lowVolt, events.nvmDone, groupSet, tickOverflow};
	assign ackNow = ce && core.ack && irqReq;
	assign ackClr = ackNow ? NUM_VEC'(1) << vecIndex : '0;

	// set wins over every clear
	generate
		for (genvar i = 0; i < NUM_VEC; i++) begin : g_flag
			assign next_flags[i] = flagSet[i] | (flags[i] & ~(ackClr[i] | (wrFlags & bus.hwdata[i])));
		end
		for (genvar j = 0; j < NUM_MEMBERS; j++) begin : g_member
			assign next_memberFlags[j] = events.member[j] | (memberFlags[j] & ~(wrMember & bus.hwdata[j]));
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			flags <= '0;
			memberFlags <= '0;
		end else if (ce) begin
			flags <= next_flags;
			memberFlags <= next_memberFlags;
		end
	end

	// request and vector selection
	assign pend = flags & vecEnable;
	always_comb begin
		pick = 4'h0;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				pick = 4'(i);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irqReq <= 1'b0;
			vecIndex <= 4'h0;
			vecAddr <= VEC_BASE;
		end else if (ce) begin
			irqReq <= globalEnable && !core.stackFull && (|pend) && !ackNow;
			vecIndex <= pick;
			vecAddr <= VEC_BASE + VEC_STEP * {12'h000, pick};
		end
	end

	// wake on any rising flag
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prevAll <= '0;
			wake <= 1'b0;
		end else if (ce) begin
			prevAll <= {flags, memberFlags};
			wake <= |({flags, memberFlags} & ~prevAll);
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence ackSeq;
		ce && core.ack && irqReq && !flagSet[vecIndex];
	endsequence
	sequence riseSeq;
		ce && |({next_flags, next_memberFlags} & ~{flags, memberFlags}) ##1 ce;
	endsequence

	chk_tick_flag_set: assert property (ce && tickOverflow |=> flags[VEC_TICK])
		else $error("tick overflow did not set tick flag");
	chk_tick_vector: assert property (irqReq && vecIndex == VEC_TICK && $past(ce) |->
		$past(globalEnable && vecEnable[VEC_TICK] && flags[VEC_TICK] && !core.stackFull))
		else $error("tick vectored without its conditions");
	chk_ack_clears: assert property (ackSeq |=> !flags[$past(vecIndex)] && !globalEnable)
		else $error("service did not clear flag and global enable");
	chk_reserved_zero: assert property (ce && addrTake && !bus.hwrite && bus.haddr[ADDR_W-1:0] == ADDR_TICK_CONTROL
		|=> readData[3:0] == 4'h0)
		else $error("tick control low bits read nonzero");
	chk_group_set: assert property (ce && (|memberHit) |=> |flags[NUM_GROUPS:1])
		else $error("enabled member event raised no group flag");
	chk_member_kept: assert property (ce && !wrMember |=> ($past(memberFlags) & ~memberFlags) == '0)
		else $error("member flag lost without software clear");
	chk_stack_block: assert property (ce && core.stackFull |=> !irqReq)
		else $error("request raised while stack full");
	chk_wake_rise: assert property (riseSeq |=> wake)
		else $error("rising flag did not wake");
	chk_return_from_interrupt_enable: assert property (ce && core.return_from_interrupt && !ackNow |=> globalEnable)
		else $error("return from interrupt left global enable clear");
	chk_priority: assert property (irqReq && $past(ce) |->
		($past(pend) & ~({NUM_VEC{1'b1}} << vecIndex)) == '0)
		else $error("lower vector pending but not chosen");
endmodule // irq_tick_ctrl

// ==== verif/core_model.sv ====
// behavioural processor core that takes vectors and returns from them
`timescale 1ns/10ps
module core_model import irq_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// device side
	input wire core_out_type coreOut,
	output core_in_type core,
	// bench control and record
	input wire logic stackHold,
	input wire logic [31:0] retiGap,
	output int ackCount,
	output logic [3:0] ackIdx,
	output logic [15:0] ackVec
);
	int gap;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			core <= '0;
			ackCount <= 0;
			ackIdx <= '0;
			ackVec <= '0;
			gap <= 0;
		end else begin
			core.stackFull <= stackHold;
			core.ack <= coreOut.req && !core.ack && !stackHold;
			core.return_from_interrupt <= (gap == 1);
			if (core.ack && coreOut.req) begin
				ackCount <= ackCount + 1;
				ackIdx <= coreOut.index;
				ackVec <= coreOut.vector;
				gap <= retiGap;
			end else if (gap != 0) begin
				gap <= gap - 1;
			end
		end
	end
endmodule // core_model

// ==== verif/periodic_tick_and_shared_irq_logic_bench.sv ====
// self-checking bench for the tick and interrupt block
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin errTotal++; $display("Error %s exp %h got %h", n, e, s); end end
module periodic_tick_and_shared_irq_logic_bench;
	import irq_pkg::*;
	logic clk_sys;
	logic rstn;
	ahb_req_type bus;
	ahb_resp_type busResp;
	src_event_type events;
	core_in_type core;
	core_out_type coreOut;
	logic stackHold;
	logic ce;
	logic ceRand;
	ahb_req_type busIn;
	logic [3:0] ackIdx;
	logic [15:0] ackVec;
	logic [31:0] d;
	int ackCount, cyc, wakes, errTotal, compares, seed, m, c, w, t0, t1;
	irq_tick_ctrl #(.TICK_BASE_CYCLES(16)) i_irq_tick_ctrl (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .bus(busIn),
		.busResp(busResp), .events(events), .core(core), .coreOut(coreOut));
	core_model i_core_model (.clk_sys(clk_sys), .rstn(rstn), .coreOut(coreOut), .core(core), .stackHold(stackHold),
		.retiGap(32'h8), .ackCount(ackCount), .ackIdx(ackIdx), .ackVec(ackVec));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		ce <= !ceRand || ({$random(seed)} % 4 != 0);
		if (coreOut.wake === 1'b1) wakes <= wakes + 1;
	end
	// the single slave's hreadyout is the bus's hready
	always_comb begin
		busIn = bus;
		busIn.hready = busResp.hreadyout;
	end
	task automatic conclude();
		if (errTotal == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (busResp.hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			errTotal++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		bus.haddr <= {24'h0, a};
		bus.htrans <= 2'h2;
		bus.hwrite <= 1'b1;
		waitRdy();
		bus.htrans <= 2'h0;
		bus.hwdata <= v;
		waitRdy();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		bus.haddr <= {24'h0, a};
		bus.htrans <= 2'h2;
		bus.hwrite <= 1'b0;
		waitRdy();
		bus.htrans <= 2'h0;
		waitRdy();
		v = busResp.hrdata;
		`CHK("hresp", 1'b0, busResp.hresp)
	endtask
	task automatic pulse(input logic [19:0] v);
		@(posedge clk_sys);
		events[20:1] <= v;
		@(posedge clk_sys);
		events[20:1] <= '0;
	endtask
	task automatic waitAck(output int t);
		int n, k;
		n = 0;
		k = ackCount;
		while (ackCount == k && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 2000) begin
			errTotal++;
			conclude();
		end
		t = cyc;
	endtask
	function automatic logic [15:0] expVec(input logic [3:0] i);
		return 16'h0004 + {10'h0, i, 2'h0};
	endfunction
	task automatic expectAck(input logic [3:0] i);
		waitAck(t0);
		`CHK("index", i, ackIdx)
		`CHK("vector", expVec(i), ackVec)
	endtask
	initial begin
		seed = 32'h4a2b2cc2;
		bus = '{hsel: 1'b1, hready: 1'b1, default: '0};
		events = '0;
		stackHold = 1'b0;
		ceRand = 1'b1;
		{cyc, wakes, errTotal, compares} = '0;
		rstn = 1'b0;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h00, d);
		`CHK("tick reset", 32'h30, d)
		wr(8'h00, 32'hffffff0f);
		rd(8'h00, d);
		`CHK("tick low bits", 32'h0, d)
		wr(8'h00, 32'h0);
		rd(8'h40, d);
		`CHK("unmapped", 32'h0, d)
		ceRand <= 1'b0;
		wr(8'h04, 32'hfff);
		wr(8'h10, 32'h1ffff);
		for (int i = 0; i < 3; i++) begin
			pulse(20'h80000 >> i);
			expectAck(4'h8 + 4'(i));
			rd(8'h14, d);
			`CHK("global cleared", 1'b0, d[6])
			rd(8'h08, d);
			`CHK("flag cleared", 1'b0, d[8+i])
			repeat (12) @(posedge clk_sys);
			rd(8'h14, d);
			`CHK("global restored", 1'b1, d[6])
		end
		repeat (10) begin
			m = {$random(seed)} % 17;
			pulse(20'h1 << m);
			expectAck(4'h1 + {1'b0, MEMBER_GROUP[m]});
			rd(8'h0c, d);
			`CHK("member kept", 32'h1 << m, d)
			wr(8'h0c, 32'h1ffff);
			repeat (8) @(posedge clk_sys);
			rd(8'h0c, d);
			`CHK("member cleared", 32'h0, d)
		end
		wr(8'h10, 32'h0);
		wr(8'h04, 32'h1);
		c = ackCount;
		w = wakes;
		pulse(20'h00008);
		pulse(20'h20000);
		repeat (20) @(posedge clk_sys);
		`CHK("disabled ack", c, ackCount)
		`CHK("wake count", w + 2, wakes)
		wr(8'h08, 32'h7ff);
		wr(8'h0c, 32'h1ffff);
		wr(8'h04, 32'hfff);
		stackHold <= 1'b1;
		repeat (3) @(posedge clk_sys);
		pulse(20'hc0000);
		repeat (20) @(posedge clk_sys);
		`CHK("stack full", c, ackCount)
		stackHold <= 1'b0;
		expectAck(4'h8);
		expectAck(4'h9);
		wr(8'h04, 32'h3);
		events.tickOsc <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 4; p++) begin
				wr(8'h00, 32'h80 | (s << 6) | (p << 4));
				waitAck(t0);
				`CHK("tick index", 4'h0, ackIdx)
				waitAck(t1);
				`CHK("tick period", (s ? 64 : 16) << p, t1 - t0)
				wr(8'h00, 32'h0);
				repeat (20) @(posedge clk_sys);
				wr(8'h08, 32'h1);
			end
		end
		conclude();
	end
endmodule // periodic_tick_and_shared_irq_logic_bench
